// File: core/dfc_pin_mux.sv
// shared control pin decoder with bus status and recovered data launch
`include "dfc_defs.svh"
// Operation
// RULE1 - pins take serial or strap meaning by mode
// RULE2 - serial port ignored while chip select high
// RULE3 - frame: read flag, address, write data
// RULE4 - serial input captured on sclk rising edge
// RULE5 - read data changes on sclk falling edge
// RULE6 - bypass high gives plain AMI everywhere
// RULE7 - bypass low: B3ZS or HDB3 by rate
// RULE8 - shutdown pin high powers channel receiver off
// RULE9 - register reset low restores command defaults
// RULE10 - invert high inverts clock, data on fall
// RULE11 - invert low launches data on clock rise
// RULE12 - chip select high abandons partial transfer
module dfc_pin_mux
(
	// clock and reset
	input  wire logic                  i_mclk,
	input  wire logic                  i_arst_n,
	// ahb-lite slave
	input  wire logic                  i_hsel,
	input  wire logic [31:0]           i_haddr,
	input  wire logic [1:0]            i_htrans,
	input  wire logic                  i_hwrite,
	input  wire logic [2:0]            i_hsize,
	input  wire logic [31:0]           i_hwdata,
	input  wire logic                  i_hready,
	output logic [31:0]                o_hrdata,
	output logic                       o_hreadyout,
	output logic                       o_hresp,
	// shared control pins
	input  wire logic                  i_host_mode_pin,
	input  wire logic                  i_cs_pin,
	input  wire logic                  i_serial_in_pin,
	input  wire logic                  i_sclk_pin,
	input  wire logic                  i_rx_shutdown_ch2_pin,
	input  wire logic                  i_command_reg_reset_pin,
	output logic                       o_serial_out,
	output logic                       o_serial_out_oe,
	// per-channel rate select, same clock
	input  wire logic [2:0]            i_chan_e3,
	// raw recovered clock and data from the receivers
	input  wire logic [2:0]            i_rec_clk_raw,
	input  wire logic [2:0]            i_rec_pos_raw,
	input  wire logic [2:0]            i_rec_neg_raw,
	// recovered clock and data to terminal equipment
	output logic [2:0]                 o_recovered_clock,
	output logic [2:0]                 o_recovered_pos_rail,
	output logic [2:0]                 o_recovered_neg_rail,
	// operating configuration
	output logic                       o_line_code_bypass,
	output logic [2:0]                 o_receiver_shutdown,
	output logic                       o_recovered_clock_invert,
	output dfc_pkg::dfc_line_code_t [2:0] o_line_code
);

	dfc_pkg::dfc_st_t  st_ff;     // registered state
	dfc_pkg::dfc_st_t  nxt_st;    // next state
	dfc_pkg::dfc_pins_t pins_in;  // raw pin bundle
	logic              host;      // processor-configured mode
	logic              sp_sdo;    // serial port data out
	logic              sp_sdo_oe; // serial port drive enable
	logic              sp_done;   // serial transfer finished
	logic [7:0]        sp_cfg;    // configuration command register

	// rising edge of a sampled level
	function automatic logic dfc_rise(input logic cur, input logic prev);
		dfc_rise = cur & ~prev;
	endfunction

	// line code from bypass and rate
	function automatic dfc_pkg::dfc_line_code_t dfc_code(
		input logic bypass,
		input logic e3);
		if (bypass)
			dfc_code = dfc_pkg::LC_AMI;
		else if (e3)
			dfc_code = dfc_pkg::LC_HDB3;
		else
			dfc_code = dfc_pkg::LC_B3ZS;
	endfunction

	// bundle the asynchronous inputs for the synchroniser
	assign pins_in.mode  = i_host_mode_pin;
	assign pins_in.cs_n  = i_cs_pin;
	assign pins_in.serial_in   = i_serial_in_pin;
	assign pins_in.sclk  = i_sclk_pin;
	assign pins_in.shdn2 = i_rx_shutdown_ch2_pin;
	assign pins_in.command_reg_reset  = i_command_reg_reset_pin;
	assign pins_in.rclk  = i_rec_clk_raw;
	assign pins_in.rpos  = i_rec_pos_raw;
	assign pins_in.rneg  = i_rec_neg_raw;

	// mode as seen after synchronisation
	assign host = st_ff.sync.mode;

	// serial port, live only in processor mode
	dfc_serial_port u_serial
	(
		.i_mclk      (i_mclk),
		.i_arst_n    (i_arst_n),
		.i_enable    (host & st_ff.ctrl_en), // [RULE1]
		.i_cs_n      (st_ff.sync.cs_n),
		.i_sclk      (st_ff.sync.sclk),
		.i_sdi       (st_ff.sync.serial_in),
		.i_reg_reset (host & ~st_ff.sync.command_reg_reset), // [RULE9]
		.o_sdo       (sp_sdo),
		.o_sdo_oe    (sp_sdo_oe),
		.o_done      (sp_done),
		.o_cfg       (sp_cfg)
	);

	// all next-state logic
	always_comb
	begin
		nxt_st = st_ff;
		// two-stage synchroniser, first stage read only here
		nxt_st.meta = pins_in;
		nxt_st.sync = st_ff.meta;

		// pick the meaning of the shared pins
		if (host) // [RULE1]
		begin
			// configuration comes from the command register
			nxt_st.cfg.bypass = sp_cfg[`DFC_CFG_BYPASS];
			nxt_st.cfg.shutdown = sp_cfg[`DFC_CFG_SHDN_LSB +: 3];
			nxt_st.cfg.invert = sp_cfg[`DFC_CFG_INVERT];
		end
		else
		begin
			// strap levels drive the configuration directly
			nxt_st.cfg.bypass = st_ff.sync.cs_n; // [RULE6] [RULE7]
			nxt_st.cfg.shutdown = {st_ff.sync.shdn2,
				st_ff.sync.sclk, st_ff.sync.serial_in}; // [RULE8]
			nxt_st.cfg.invert = st_ff.sync.command_reg_reset; // [RULE10] [RULE11]
		end

		// per-channel line code and recovered data launch
		nxt_st.rclk_prev = st_ff.sync.rclk;
		for (int ch = 0; ch < `DFC_NCH; ch++)
		begin
			nxt_st.lcode[ch] = dfc_code(st_ff.cfg.bypass,
				i_chan_e3[ch]); // [RULE6] [RULE7]
			if (st_ff.cfg.shutdown[ch]) // [RULE8]
			begin
				// receiver off: outputs held quiet
				nxt_st.rclk_out[ch] = 1'b0;
				nxt_st.rpos[ch] = 1'b0;
				nxt_st.rneg[ch] = 1'b0;
			end
			else
			begin
				// clock polarity follows the invert setting
				nxt_st.rclk_out[ch] = st_ff.sync.rclk[ch]
					^ st_ff.cfg.invert; // [RULE10] [RULE11]
				// data launched on raw rise: output rise or fall
				if (dfc_rise(st_ff.sync.rclk[ch], st_ff.rclk_prev[ch]))
				begin
					nxt_st.rpos[ch] = st_ff.sync.rpos[ch]; // [RULE10] [RULE11]
					nxt_st.rneg[ch] = st_ff.sync.rneg[ch];
				end
			end
		end

		// completed serial transfers
		if (sp_done)
			nxt_st.xfer_cnt = st_ff.xfer_cnt + 16'h0001;

		// bus slave: zero wait, always okay
		nxt_st.hreadyout = 1'b1;
		nxt_st.hresp = 1'b0;
		nxt_st.wr_pend = 1'b0;
		// write data phase lands in the control register
		if (st_ff.wr_pend && st_ff.wr_ofs == `DFC_CTRL_OFS)
			nxt_st.ctrl_en = i_hwdata[`DFC_CTRL_EN_BIT];
		// address phase: latch writes, answer reads
		if (i_hsel && i_htrans[1] && i_hready)
		begin
			nxt_st.wr_pend = i_hwrite;
			nxt_st.wr_ofs = i_haddr[7:0];
			if (!i_hwrite)
			begin
				unique case (i_haddr[7:0])
					`DFC_CTRL_OFS:
						nxt_st.hrdata = {31'h0, nxt_st.ctrl_en};
					`DFC_STATUS_OFS:
						nxt_st.hrdata = {24'h0, st_ff.cfg.invert,
							st_ff.cfg.shutdown, st_ff.cfg.bypass,
							sp_sdo_oe, st_ff.sync.cs_n, host};
					`DFC_XFER_OFS:
						nxt_st.hrdata = {16'h0, st_ff.xfer_cnt};
					default:
						nxt_st.hrdata = 32'h0;
				endcase
			end
		end
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			st_ff <= '0;
			st_ff.ctrl_en <= `DFC_CTRL_RESET;
			st_ff.hreadyout <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	// outputs from registers
	assign o_hrdata = st_ff.hrdata;
	assign o_hreadyout = st_ff.hreadyout;
	assign o_hresp = st_ff.hresp;
	assign o_serial_out = sp_sdo;
	assign o_serial_out_oe = sp_sdo_oe;
	assign o_recovered_clock = st_ff.rclk_out;
	assign o_recovered_pos_rail = st_ff.rpos;
	assign o_recovered_neg_rail = st_ff.rneg;
	assign o_line_code_bypass = st_ff.cfg.bypass;
	assign o_receiver_shutdown = st_ff.cfg.shutdown;
	assign o_recovered_clock_invert = st_ff.cfg.invert;
	assign o_line_code = st_ff.lcode;

endmodule

// File: inc/dfc_defs.svh
// constants for the dual-function control pin block
`ifndef DFC_DEFS_SVH
`define DFC_DEFS_SVH

// bus register byte offsets (low address byte)
`define DFC_CTRL_OFS      8'h00
`define DFC_STATUS_OFS    8'h04
`define DFC_XFER_OFS      8'h08

// control register reset value and field
`define DFC_CTRL_RESET    1'b1
`define DFC_CTRL_EN_BIT   0

// serial frame geometry
`define DFC_ADDR_W        5
`define DFC_DATA_W        8
`define DFC_NREGS         32

// command register holding the operating configuration
`define DFC_CFG_ADDR      5'h00
`define DFC_CFG_BYPASS    0
`define DFC_CFG_SHDN_LSB  1
`define DFC_CFG_INVERT    4
`define DFC_CMD_RESET     8'h00

// channel count
`define DFC_NCH           3

`endif

// File: inc/dfc_pkg.sv
// types shared by the control pin block
package dfc_pkg;

	// serial port sequencer states
	typedef enum logic [2:0]
	{
		SP_IDLE  = 3'h0,
		SP_ADDR  = 3'h1,
		SP_WDATA = 3'h2,
		SP_RDATA = 3'h3,
		SP_DONE  = 3'h4
	} dfc_sp_state_t;

	// line code chosen per channel
	typedef enum logic [1:0]
	{
		LC_AMI  = 2'h0,
		LC_B3ZS = 2'h1,
		LC_HDB3 = 2'h2
	} dfc_line_code_t;

	// operating configuration
	typedef struct packed
	{
		logic       invert;
		logic [2:0] shutdown;
		logic       bypass;
	} dfc_cfg_t;

	// external pins as sampled
	typedef struct packed
	{
		logic       mode;
		logic       cs_n;
		logic       serial_in;
		logic       sclk;
		logic       shdn2;
		logic       command_reg_reset;
		logic [2:0] rclk;
		logic [2:0] rpos;
		logic [2:0] rneg;
	} dfc_pins_t;

	// serial port state
	typedef struct packed
	{
		dfc_sp_state_t   state;
		logic            rw;
		logic [4:0]      addr;
		logic [7:0]      shreg;
		logic [2:0]      cnt;
		logic            sclk_prev;
		logic            serial_out;
		logic            sdo_oe;
		logic            done;
		logic [31:0][7:0] regs;
	} dfc_sp_st_t;

	// top-level state
	typedef struct packed
	{
		dfc_pins_t           meta;
		dfc_pins_t           sync;
		logic [2:0]          rclk_prev;
		logic [2:0]          rclk_out;
		logic [2:0]          rpos;
		logic [2:0]          rneg;
		dfc_cfg_t            cfg;
		dfc_line_code_t [2:0] lcode;
		logic                ctrl_en;
		logic [15:0]         xfer_cnt;
		logic                wr_pend;
		logic [7:0]          wr_ofs;
		logic [31:0]         hrdata;
		logic                hreadyout;
		logic                hresp;
	} dfc_st_t;

endpackage

// File: core/dfc_serial_port.sv
// serial configuration port with its command register array
`include "dfc_defs.svh"
module dfc_serial_port
(
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_arst_n,
	// synchronised port pins
	input  wire logic       i_enable,
	input  wire logic       i_cs_n,
	input  wire logic       i_sclk,
	input  wire logic       i_sdi,
	input  wire logic       i_reg_reset,
	// results
	output logic            o_sdo,
	output logic            o_sdo_oe,
	output logic            o_done,
	output logic [7:0]      o_cfg
);

	dfc_pkg::dfc_sp_st_t st_ff;   // registered state
	dfc_pkg::dfc_sp_st_t nxt_st;  // next state
	logic                rise;    // sclk rising edge seen
	logic                fall;    // sclk falling edge seen

	// edge detection against the previous sclk sample
	assign rise = i_sclk & ~st_ff.sclk_prev;
	assign fall = ~i_sclk & st_ff.sclk_prev;

	// sequencer: flag, address, then data in or out
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		nxt_st.sclk_prev = i_sclk;
		// chip select high abandons any partial frame
		if (i_cs_n || !i_enable) // [RULE2] [RULE12]
		begin
			nxt_st.state = dfc_pkg::SP_IDLE;
			nxt_st.cnt = 3'h0;
			nxt_st.sdo_oe = 1'b0;
		end
		else
		begin
			unique case (st_ff.state)
				// first bit is the read flag
				dfc_pkg::SP_IDLE:
					if (rise) // [RULE3] [RULE4]
					begin
						nxt_st.rw = i_sdi;
						nxt_st.cnt = 3'h0;
						nxt_st.state = dfc_pkg::SP_ADDR;
					end
				// address bits, most significant first
				dfc_pkg::SP_ADDR:
					if (rise) // [RULE4]
					begin
						nxt_st.addr = {st_ff.addr[3:0], i_sdi};
						nxt_st.cnt = st_ff.cnt + 3'h1;
						if (st_ff.cnt == 3'(`DFC_ADDR_W - 1))
						begin
							nxt_st.cnt = 3'h0;
							if (st_ff.rw)
							begin
								nxt_st.shreg = st_ff.regs[{st_ff.addr[3:0], i_sdi}];
								nxt_st.state = dfc_pkg::SP_RDATA;
							end
							else
								nxt_st.state = dfc_pkg::SP_WDATA;
						end
					end
				// write data, stored on the last bit
				dfc_pkg::SP_WDATA:
					if (rise) // [RULE4]
					begin
						nxt_st.shreg = {st_ff.shreg[6:0], i_sdi};
						nxt_st.cnt = st_ff.cnt + 3'h1;
						if (st_ff.cnt == 3'h7)
						begin
							nxt_st.regs[st_ff.addr] = {st_ff.shreg[6:0], i_sdi};
							nxt_st.done = 1'b1;
							nxt_st.state = dfc_pkg::SP_DONE;
						end
					end
				// read data launched on falling edges
				dfc_pkg::SP_RDATA:
					if (fall) // [RULE5]
					begin
						nxt_st.serial_out = st_ff.shreg[7];
						nxt_st.sdo_oe = 1'b1;
						nxt_st.shreg = {st_ff.shreg[6:0], 1'b0};
						nxt_st.cnt = st_ff.cnt + 3'h1;
						if (st_ff.cnt == 3'h7)
						begin
							nxt_st.done = 1'b1;
							nxt_st.state = dfc_pkg::SP_DONE;
						end
					end
				// wait for chip select to rise
				dfc_pkg::SP_DONE:
					nxt_st.state = dfc_pkg::SP_DONE;
				default:
					nxt_st.state = dfc_pkg::SP_IDLE;
			endcase
		end
		// register reset pin returns every command register to default
		if (i_reg_reset) // [RULE9]
			nxt_st.regs = {`DFC_NREGS{`DFC_CMD_RESET}};
	end

	// state register
	always_ff @(posedge i_mclk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			st_ff <= '0;
			st_ff.state <= dfc_pkg::SP_IDLE;
		end
		else
			st_ff <= nxt_st;
	end

	// outputs straight from state
	assign o_sdo = st_ff.serial_out;
	assign o_sdo_oe = st_ff.sdo_oe;
	assign o_done = st_ff.done;
	assign o_cfg = st_ff.regs[`DFC_CFG_ADDR];

endmodule

// File: verif/dfc_pin_mux_assertions.sv
// port assertions for the shared control pin decoder
module dfc_pin_mux_chk
(
	// clock and reset
	input  wire logic                      i_mclk,
	input  wire logic                      i_arst_n,
	// shared pins and rate select
	input  wire logic                      i_host_mode_pin,
	input  wire logic                      i_cs_pin,
	input  wire logic                      i_serial_in_pin,
	input  wire logic                      i_sclk_pin,
	input  wire logic                      i_rx_shutdown_ch2_pin,
	input  wire logic                      i_command_reg_reset_pin,
	input  wire logic [2:0]                i_chan_e3,
	// decoded results
	input  wire logic                      o_serial_out,
	input  wire logic                      o_serial_out_oe,
	input  wire logic                      o_line_code_bypass,
	input  wire logic [2:0]                o_receiver_shutdown,
	input  wire logic                      o_recovered_clock_invert,
	input  wire logic [2:0]                o_recovered_clock,
	input  wire logic [2:0]                o_recovered_pos_rail,
	input  wire logic [2:0]                o_recovered_neg_rail,
	input  wire dfc_pkg::dfc_line_code_t [2:0] o_line_code
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	// strap mode and expected per-channel codes with coding on
	wire logic       st = !i_host_mode_pin;
	wire logic [5:0] lc = {i_chan_e3[2] ? 2'h2 : 2'h1,
		i_chan_e3[1] ? 2'h2 : 2'h1, i_chan_e3[0] ? 2'h2 : 2'h1};
	property p_byp_on;
		(st && i_cs_pin)[*6] |-> o_line_code_bypass && o_line_code == 6'h00;
	endproperty
	a_byp_on: assert property (p_byp_on)
		else $error("bypass pin high but coding on");
	property p_byp_off;
		(st && !i_cs_pin && $stable(i_chan_e3))[*6] |-> o_line_code == lc;
	endproperty
	a_byp_off: assert property (p_byp_off)
		else $error("line code wrong for rate");
	property p_shdn;
		(st && $stable({i_rx_shutdown_ch2_pin, i_sclk_pin, i_serial_in_pin}))[*6]
		|-> o_receiver_shutdown ==
		{i_rx_shutdown_ch2_pin, i_sclk_pin, i_serial_in_pin};
	endproperty
	a_shdn: assert property (p_shdn)
		else $error("shutdown does not follow pins");
	property p_inv;
		(st && i_command_reg_reset_pin)[*6] |-> o_recovered_clock_invert;
	endproperty
	a_inv: assert property (p_inv)
		else $error("invert pin high but not inverted");
	property p_strap_quiet;
		st[*6] |-> !o_serial_out_oe;
	endproperty
	a_strap_quiet: assert property (p_strap_quiet)
		else $error("serial out driven in strap mode");
	property p_clear;
		(!st && !i_command_reg_reset_pin)[*6] |-> !o_line_code_bypass &&
		o_receiver_shutdown == 3'h0 && !o_recovered_clock_invert;
	endproperty
	a_clear: assert property (p_clear)
		else $error("register reset did not restore defaults");
	property p_cs_idle;
		(!st && i_cs_pin)[*6] |-> !o_serial_out_oe;
	endproperty
	a_cs_idle: assert property (p_cs_idle)
		else $error("port active with chip select high");
	property p_fall;
		o_serial_out_oe && $past(o_serial_out_oe) && $changed(o_serial_out)
		|-> !$past(i_sclk_pin, 2);
	endproperty
	a_fall: assert property (p_fall)
		else $error("serial out changed outside falling edge");
	// rails of live channel 0 move only with the launching clock edge
	property p_launch;
		!$past(o_receiver_shutdown[0]) &&
		$changed({o_recovered_pos_rail[0], o_recovered_neg_rail[0]})
		|-> o_recovered_clock[0] == !$past(o_recovered_clock_invert);
	endproperty
	a_launch: assert property (p_launch)
		else $error("recovered rails moved off the launch edge");
	// main scenarios reached
	c_read: cover property (o_serial_out_oe && $changed(o_serial_out));
	c_byp: cover property ($rose(o_line_code_bypass));
	c_clear: cover property (!st && !i_command_reg_reset_pin);
endmodule
bind dfc_pin_mux dfc_pin_mux_chk u_dfc_pin_mux_chk
(
	.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_host_mode_pin(i_host_mode_pin),
	.i_cs_pin(i_cs_pin), .i_serial_in_pin(i_serial_in_pin),
	.i_sclk_pin(i_sclk_pin), .i_rx_shutdown_ch2_pin(i_rx_shutdown_ch2_pin),
	.i_command_reg_reset_pin(i_command_reg_reset_pin), .i_chan_e3(i_chan_e3),
	.o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe),
	.o_line_code_bypass(o_line_code_bypass),
	.o_receiver_shutdown(o_receiver_shutdown),
	.o_recovered_clock_invert(o_recovered_clock_invert),
	.o_recovered_clock(o_recovered_clock),
	.o_recovered_pos_rail(o_recovered_pos_rail),
	.o_recovered_neg_rail(o_recovered_neg_rail),
	.o_line_code(o_line_code)
);

// File: verif/dfc_host_model.sv
// serial host model driving the configuration port pins
module dfc_host_model
(
	// clock
	input  wire logic i_mclk,
	// port pins
	output logic      o_cs_n,
	output logic      o_sdi,
	output logic      o_sclk,
	input  wire logic i_sdo
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle: deselected, link clock still and low
	initial
	begin
		o_cs_n = 1'b1;
		o_sdi  = 1'b0;
		o_sclk = 1'b0;
	end
	// static levels when the pins serve as straps
	task set_pins(input logic cs, input logic serial_in, input logic sclk);
		@(posedge i_mclk);
		o_cs_n <= cs;
		o_sdi  <= serial_in;
		o_sclk <= sclk;
	endtask
	// n link cycles of vec msb first; last 8 sampled bits come back
	task shift(input logic sel, input logic [13:0] vec, input int n,
		output logic [7:0] q);
		q = 8'h00;
		@(posedge i_mclk);
		o_cs_n <= !sel;
		for (int i = 0; i < n; i++)
		begin
			o_sclk <= 1'b0;
			o_sdi  <= (i < 14) ? vec[13 - i] : !o_sdi;
			repeat (4) @(posedge i_mclk);
			o_sclk <= 1'b1;
			repeat (3) @(posedge i_mclk);
			// sample late in the high phase, well settled
			@(negedge i_mclk);
			q = {q[6:0], i_sdo};
			@(posedge i_mclk);
		end
		o_sclk <= 1'b0;
		repeat (4) @(posedge i_mclk);
		o_cs_n <= 1'b1;
		o_sdi  <= !o_sdi;
		repeat (8) @(posedge i_mclk);
	endtask
endmodule

// File: verif/dfc_pin_mux_bench.sv
// self-checking bench for the shared control pin decoder
module dfc_pin_mux_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, arst_n, hsel, hwrite, mode, shdn2, command_reg_reset, rdy, resp;
	logic        serial_out, oe, cs_n, serial_in, sclk, byp, inv;
	logic [1:0]  htrans;
	logic [2:0]  e3, rclk, rpos, rneg, rc, rp, rn, shdn;
	logic [31:0] haddr, hwdata, hrdata;
	logic [5:0]  lcode;
	int          bad_count, compares;
	// released serial out shows the inverse level
	wire logic   sdo_w = oe ? serial_out : !serial_out;
	dfc_pin_mux u_dfc_pin_mux
	(
		.i_mclk(clk), .i_arst_n(arst_n), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata),
		.o_hreadyout(rdy), .o_hresp(resp), .i_host_mode_pin(mode),
		.i_cs_pin(cs_n), .i_serial_in_pin(serial_in), .i_sclk_pin(sclk),
		.i_rx_shutdown_ch2_pin(shdn2), .i_command_reg_reset_pin(command_reg_reset),
		.o_serial_out(serial_out), .o_serial_out_oe(oe), .i_chan_e3(e3),
		.i_rec_clk_raw(rclk), .i_rec_pos_raw(rpos), .i_rec_neg_raw(rneg),
		.o_recovered_clock(rc), .o_recovered_pos_rail(rp),
		.o_recovered_neg_rail(rn), .o_line_code_bypass(byp),
		.o_receiver_shutdown(shdn), .o_recovered_clock_invert(inv),
		.o_line_code(lcode)
	);
	dfc_host_model u_dfc_host_model
	(
		.i_mclk(clk), .o_cs_n(cs_n), .o_sdi(serial_in), .o_sclk(sclk),
		.i_sdo(sdo_w)
	);
	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one single ahb-lite transfer, read data taken at data phase end
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h000000, a};
		hwrite <= wr;
		do @(posedge clk); while (rdy !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= wd;
		do @(posedge clk); while (rdy !== 1'b1);
		rd = hrdata;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		ahb(1'b0, a, 32'h0, d);
		chk(d, exp);
		chk(resp, 1'b0);
		chk(rdy, 1'b1);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] d;
		ahb(1'b1, a, wd, d);
	endtask
	task settle;
		repeat (8) @(posedge clk);
	endtask
	// control reset value, write and readback, unmapped place
	task t_regs;
		rd_chk(8'h00, 32'h1);
		wr(8'h00, 32'h0);
		rd_chk(8'h00, 32'h0);
		wr(8'h00, 32'h1);
		wr(8'h0C, 32'hFFFFFFFF);
		rd_chk(8'h0C, 32'h0);
		rd_chk(8'h00, 32'h1);
	endtask
	// strap levels decoded, both bypass settings, mixed rates
	task t_strap;
		e3 <= 3'h2;
		shdn2 <= 1'b1;
		u_dfc_host_model.set_pins(1'b1, 1'b1, 1'b0);
		settle;
		chk(byp, 1'b1);
		chk(lcode, 6'h00);
		chk(shdn, 3'h5);
		chk(oe, 1'b0);
		shdn2 <= 1'b0;
		u_dfc_host_model.set_pins(1'b0, 1'b0, 1'b1);
		settle;
		chk(byp, 1'b0);
		chk(lcode, 6'h19);
		chk(shdn, 3'h2);
		rd_chk(8'h04, 32'h20);
	endtask
	// recovered clock polarity and rail launch on raw rise
	task t_rec(input logic iv);
		command_reg_reset <= iv;
		rclk <= 3'h0;
		rpos <= 3'h5;
		rneg <= 3'h2;
		u_dfc_host_model.set_pins(1'b0, 1'b0, 1'b0);
		settle;
		chk(inv, iv);
		chk(rc, {3{iv}});
		rclk <= 3'h7;
		settle;
		chk(rc, {3{!iv}});
		chk({rp, rn}, 6'h2A);
		rpos <= 3'h2;
		rneg <= 3'h5;
		settle;
		chk({rp, rn}, 6'h2A);
		rclk <= 3'h0;
		settle;
		rclk <= 3'h7;
		settle;
		chk({rp, rn}, 6'h15);
	endtask
	// serial write, read back, deselected, aborted frame, register reset
	task t_host;
		logic [7:0] q;
		command_reg_reset <= 1'b1;
		mode <= 1'b1;
		settle;
		u_dfc_host_model.shift(1'b1, {1'b0, 5'h00, 8'h13}, 14, q);
		settle;
		chk({inv, shdn, byp}, 5'h13);
		u_dfc_host_model.shift(1'b1, {1'b1, 5'h00, 8'h00}, 14, q);
		chk(q, 8'h13);
		rd_chk(8'h08, 32'h2);
		u_dfc_host_model.shift(1'b0, {1'b0, 5'h00, 8'h00}, 14, q);
		settle;
		chk({inv, shdn, byp}, 5'h13);
		// port switched off by the control register ignores a full frame
		wr(8'h00, 32'h0);
		u_dfc_host_model.shift(1'b1, {1'b0, 5'h00, 8'h1F}, 14, q);
		settle;
		chk({inv, shdn, byp}, 5'h13);
		wr(8'h00, 32'h1);
		u_dfc_host_model.shift(1'b1, {1'b0, 5'h00, 8'h00}, 4, q);
		u_dfc_host_model.shift(1'b1, {1'b0, 5'h00, 8'h04}, 14, q);
		settle;
		chk({inv, shdn, byp}, 5'h04);
		command_reg_reset <= 1'b0;
		settle;
		chk({inv, shdn, byp}, 5'h00);
		command_reg_reset <= 1'b1;
		settle;
		u_dfc_host_model.shift(1'b1, {1'b1, 5'h00, 8'h00}, 14, q);
		chk(q, 8'h00);
		// only the four frames completed with the port enabled were counted
		rd_chk(8'h08, 32'h4);
	endtask
	task finish_test;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// 250 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = !clk;
	end
	// watchdog against a hung wait
	initial
	begin
		#80000;
		bad_count++;
		finish_test;
	end
	// main sequence
	initial
	begin
		{arst_n, hsel, hwrite, mode, shdn2, command_reg_reset, htrans} = 8'h00;
		{e3, rclk, rpos, rneg} = 12'h000;
		{haddr, hwdata} = 64'h0;
		bad_count = 0;
		compares = 0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_regs;
		t_strap;
		t_rec(1'b0);
		t_rec(1'b1);
		t_host;
		finish_test;
	end
endmodule
